// ### memory_config_byte_lanes.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "memory_config_cfg.svh"
// Operation
// - Byte-order pin high big, low little.
// - Little order swaps the four data byte lanes.
// - Little order reverses column strobes, swaps masks.
// - Bit 30 floats memory clock during grant.
// - Bit 29 clear: masks high until SDRAM access.
// - Bit 28: clock enable low after 8 idle.
// - Bit 27 shows internal register accesses externally.
// - Bits 26 and 25 enable the re-mappers.
// - Bit 24 honours the write-in-page hint.
// - Bits 23..21 enable chip selects in user space.
// - Bit 20 enables chip select 1 in banks.
// - Field layout of banks, rows, columns, widths.
// - Bank type 11,10,01,00 decodes to memory kinds.
// - Width bit set 32-bit, clear 16-bit port.
// - Chip-select 0 width bit follows boot strap.
module memory_config_byte_lanes (
  input wire logic clk,
  input wire logic rst,
  input wire memory_config_pkg::reg_req_s req,
  output logic [31:0] rdata,
  input wire logic big_order,
  input wire logic boot_test_strap,
  input wire logic [31:0] core_wdata,
  output logic [31:0] core_rdata,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  input wire logic [3:0] core_column_strobe_n,
  output logic [3:0] column_strobe_n,
  input wire logic core_upper_mask,
  input wire logic core_lower_mask,
  output logic upper_byte_mask,
  output logic lower_byte_mask,
  input wire logic external_bus_grant_n,
  output logic memory_clock_out,
  output logic memory_clock_oe_n,
  input wire logic powerdown_exit,
  input wire logic sdram_access,
  output logic sdram_clock_enable,
  input wire memory_config_pkg::show_access_s internal_access,
  output logic show_read_n,
  output logic [12:0] show_addr,
  output logic [31:0] show_data,
  output logic card_register_select_n,
  input wire logic write_in_page_hint,
  output logic keep_page,
  output logic remapper_two_en,
  output logic remapper_one_en,
  output logic [3:1] cs_user_space_en,
  output logic cs1_bank_space_en,
  output logic [3:0] cs_wide_port,
  output memory_config_pkg::bank_type_e bank1_type,
  output memory_config_pkg::bank_type_e bank0_type,
  output logic [1:0] bank1_row_map,
  output logic [1:0] bank0_row_map,
  output logic [3:0] bank1_column_map,
  output logic [3:0] bank0_column_map
);
  import memory_config_pkg::*;

  // Swaps the four byte lanes when little byte order is selected.
  function automatic logic [31:0] map_lanes(input logic [31:0] d, input logic big);
    map_lanes = big ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // Reverses the column strobe numbering when little byte order is selected.
  function automatic logic [3:0] map_strobes(input logic [3:0] s, input logic big);
    map_strobes = big ? s : {s[0], s[1], s[2], s[3]};
  endfunction

  logic [31:0] config_reg; // Stored configuration word, bit 31 held at zero.
  logic strap_taken; // Set once the boot strap has been captured.
  logic [2:0] idle_count; // Consecutive cycles without an SDRAM access.
  logic clock_phase; // Divided memory clock.
  mask_state_e mask_state; // Byte-mask init state.

  // Register writes, strap capture after reset release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_reg <= `MEMORY_CONFIG_ZERO_RESET;
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
      if (req.wr && req.addr == `MEMORY_CONFIG_ZERO_OFFSET) begin
        // Bit 31 is never stored.
        config_reg <= {1'b0, req.wdata[30:0]};
      end else if (!strap_taken) begin
        // The chip-select 0 width bit takes the strap level once.
        config_reg[`POS_CS_WIDE] <= boot_test_strap;
      end
    end
  end

  // Read data stand in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd && req.addr == `MEMORY_CONFIG_ZERO_OFFSET) begin
      rdata <= {1'b0, config_reg[30:0]};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Data lanes in both directions follow the byte-order pin.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= 32'h0000_0000;
      core_rdata <= 32'h0000_0000;
    end else begin
      data_out <= map_lanes(core_wdata, big_order);
      core_rdata <= map_lanes(data_in, big_order);
    end
  end

  // Column strobes follow the byte-order pin; idle high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      column_strobe_n <= 4'hf;
    end else begin
      column_strobe_n <= map_strobes(core_column_strobe_n, big_order);
    end
  end

  // Byte-mask init state: high after power-down exit until the first SDRAM access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_state <= mask_normal;
    end else begin
      unique case (mask_state)
        mask_normal: begin
          // Only entered when the init function is enabled.
          if (powerdown_exit && !config_reg[`POS_MASK_INIT_DIS]) begin
            mask_state <= mask_hold_high;
          end
        end
        mask_hold_high: begin
          // The first SDRAM access releases the masks.
          if (sdram_access) begin
            mask_state <= mask_normal;
          end
        end
      endcase
    end
  end

  // Byte masks swap roles in little order and are forced high while holding.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_byte_mask <= 1'b0;
      lower_byte_mask <= 1'b0;
    end else if (mask_state == mask_hold_high && !sdram_access) begin
      upper_byte_mask <= 1'b1;
      lower_byte_mask <= 1'b1;
    end else begin
      upper_byte_mask <= big_order ? core_upper_mask : core_lower_mask;
      lower_byte_mask <= big_order ? core_lower_mask : core_upper_mask;
    end
  end

  // Memory clock divides the core clock by two.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_phase <= 1'b0;
    end else begin
      clock_phase <= ~clock_phase;
    end
  end

  // Clock output and its enable; the enable is high while the pin floats.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_clock_out <= 1'b0;
      memory_clock_oe_n <= 1'b0;
    end else begin
      memory_clock_out <= clock_phase;
      memory_clock_oe_n <= !external_bus_grant_n && config_reg[`POS_CLOCK_FLOAT];
    end
  end

  // Idle counter saturates at the power-down count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_count <= 3'h0;
    end else if (sdram_access) begin
      idle_count <= 3'h0;
    end else if (idle_count != `IDLE_POWERDOWN_CYCLES) begin
      idle_count <= idle_count + 3'h1;
    end
  end

  // Clock enable drops once the idle count is reached and power-down is allowed.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdram_clock_enable <= 1'b1;
    end else begin
      sdram_clock_enable <= !(config_reg[`POS_IDLE_PD_EN] && !sdram_access
        && idle_count == `IDLE_POWERDOWN_CYCLES);
    end
  end

  // Debug show: latch the access, strobe low one cycle, rising edge marks sampling.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      show_read_n <= 1'b1;
      show_addr <= 13'h0000;
      show_data <= 32'h0000_0000;
      card_register_select_n <= 1'b1;
    end else if (internal_access.valid && config_reg[`POS_DEBUG_SHOW]) begin
      show_read_n <= !internal_access.is_read;
      show_addr <= internal_access.addr;
      show_data <= internal_access.data;
      card_register_select_n <= 1'b0;
    end else begin
      // The select rises again, which marks the sampling point outside.
      card_register_select_n <= 1'b1;
    end
  end

  // Page retention honours the hint only when enabled.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keep_page <= 1'b0;
    end else begin
      keep_page <= write_in_page_hint && config_reg[`POS_PAGE_RETAIN];
    end
  end

  // Enables and geometry come straight from the register flops.
  assign remapper_two_en = config_reg[`POS_REMAP_TWO];
  assign remapper_one_en = config_reg[`POS_REMAP_ONE];
  assign cs_user_space_en = config_reg[`POS_CS3_USER:`POS_CS1_USER];
  assign cs1_bank_space_en = config_reg[`POS_CS1_BANK];
  assign cs_wide_port = config_reg[`POS_CS_WIDE+3:`POS_CS_WIDE];
  assign bank1_type = bank_type_e'(config_reg[`POS_BANK1_TYPE+1:`POS_BANK1_TYPE]);
  assign bank0_type = bank_type_e'(config_reg[`POS_BANK0_TYPE+1:`POS_BANK0_TYPE]);
  assign bank1_row_map = config_reg[`POS_BANK1_ROW+1:`POS_BANK1_ROW];
  assign bank0_row_map = config_reg[`POS_BANK0_ROW+1:`POS_BANK0_ROW];
  assign bank1_column_map = config_reg[`POS_BANK1_COL+3:`POS_BANK1_COL];
  assign bank0_column_map = config_reg[`POS_BANK0_COL+3:`POS_BANK0_COL];

  // Checks next to the logic they guard; the sampled reset in the antecedents that carry it keeps the
  // edge that releases reset from judging outputs that were still held in reset.
  property p_lanes_little;
    @(posedge clk) disable iff (rst)
      !rst && !big_order
      |=> data_out[7:0] == $past(core_wdata[31:24]) && data_out[31:24] == $past(core_wdata[7:0]);
  endproperty
  a_lanes_little: assert property (p_lanes_little) else $error("little lane swap wrong");

  property p_lanes_big;
    @(posedge clk) disable iff (rst)
      !rst && big_order |=> data_out == $past(core_wdata) && core_rdata == $past(data_in);
  endproperty
  a_lanes_big: assert property (p_lanes_big) else $error("big order not straight");

  property p_strobe_reverse;
    @(posedge clk) disable iff (rst)
      !rst && !big_order |=> column_strobe_n[3] == $past(core_column_strobe_n[0]);
  endproperty
  a_strobe_reverse: assert property (p_strobe_reverse) else $error("strobe reversal wrong");

  property p_clock_float;
    @(posedge clk) disable iff (rst)
      !rst && !external_bus_grant_n && config_reg[`POS_CLOCK_FLOAT] |=> memory_clock_oe_n;
  endproperty
  a_clock_float: assert property (p_clock_float) else $error("clock not floated");

  property p_clock_runs;
    @(posedge clk) disable iff (rst)
      !rst && !config_reg[`POS_CLOCK_FLOAT] |=> !memory_clock_oe_n;
  endproperty
  a_clock_runs: assert property (p_clock_runs) else $error("clock floated");

  property p_mask_hold;
    @(posedge clk) disable iff (rst)
      powerdown_exit && !config_reg[`POS_MASK_INIT_DIS] && mask_state == mask_normal ##1 !sdram_access
      |=> upper_byte_mask && lower_byte_mask;
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("masks not high");

  property p_idle_powerdown;
    @(posedge clk) disable iff (rst)
      (config_reg[`POS_IDLE_PD_EN] && !sdram_access) [*8] |=> !sdram_clock_enable;
  endproperty
  a_idle_powerdown: assert property (p_idle_powerdown) else $error("no power-down");

  property p_access_wakes;
    @(posedge clk) disable iff (rst)
      sdram_access |=> sdram_clock_enable;
  endproperty
  a_access_wakes: assert property (p_access_wakes) else $error("clock enable low after access");

  property p_show_strobe;
    @(posedge clk) disable iff (rst)
      internal_access.valid && config_reg[`POS_DEBUG_SHOW]
      |=> !card_register_select_n && show_addr == $past(internal_access.addr);
  endproperty
  a_show_strobe: assert property (p_show_strobe) else $error("debug show missing");

  property p_show_quiet;
    @(posedge clk) disable iff (rst)
      !rst && !config_reg[`POS_DEBUG_SHOW] |=> card_register_select_n;
  endproperty
  a_show_quiet: assert property (p_show_quiet) else $error("debug strobe while disabled");

  property p_page_hint;
    @(posedge clk) disable iff (rst)
      !rst && write_in_page_hint && !config_reg[`POS_PAGE_RETAIN] |=> !keep_page;
  endproperty
  a_page_hint: assert property (p_page_hint) else $error("hint not ignored");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      !rst && req.rd && req.addr == `MEMORY_CONFIG_ZERO_OFFSET
      |=> !rdata[`POS_RESERVED] && rdata[30:0] == $past(config_reg[30:0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit or read data wrong");

  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      !rst && !(req.rd && req.addr == `MEMORY_CONFIG_ZERO_OFFSET) |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("read data not zero");

  property p_strap;
    @(posedge clk) disable iff (rst)
      !rst && !strap_taken && !(req.wr && req.addr == `MEMORY_CONFIG_ZERO_OFFSET)
      |=> cs_wide_port[0] == $past(boot_test_strap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");
endmodule

// ### memory_config_byte_lanes_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
// Self-checking bench for the byte-lane mapper and its configuration register.
module memory_config_byte_lanes_test;
  import memory_config_pkg::*;
  logic clk = 0, rst = 1, big_order = 1, boot_test_strap = 1, core_upper_mask = 0, core_lower_mask = 0;
  logic external_bus_grant_n = 1, powerdown_exit = 0, sdram_access = 0, write_in_page_hint = 0;
  reg_req_s req = '0;
  show_access_s internal_access = '0;
  logic [31:0] core_wdata = 0, rdata, core_rdata, data_in, data_out, show_data, w, ed;
  logic [3:0] core_column_strobe_n = 4'hf, column_strobe_n, cs_wide_port, bank1_column_map, bank0_column_map;
  logic upper_byte_mask, lower_byte_mask, memory_clock_out, memory_clock_oe_n, sdram_clock_enable, en;
  logic show_read_n, card_register_select_n, keep_page, remapper_two_en, remapper_one_en, cs1_bank_space_en;
  logic [12:0] show_addr;
  logic [3:1] cs_user_space_en;
  logic [1:0] bank1_row_map, bank0_row_map;
  bank_type_e bank1_type, bank0_type;
  int n_errors = 0, num_checks = 0, seed = 26451, k, c;
  // The clock toggles every half period of 100 ns.
  always #50 clk = ~clk;
  memory_config_byte_lanes dut (.clk, .rst, .req, .rdata, .big_order, .boot_test_strap, .core_wdata,
    .core_rdata, .data_in, .data_out, .core_column_strobe_n, .column_strobe_n, .core_upper_mask,
    .core_lower_mask, .upper_byte_mask, .lower_byte_mask, .external_bus_grant_n, .memory_clock_out,
    .memory_clock_oe_n, .powerdown_exit, .sdram_access, .sdram_clock_enable, .internal_access, .show_read_n,
    .show_addr, .show_data, .card_register_select_n, .write_in_page_hint, .keep_page, .remapper_two_en,
    .remapper_one_en, .cs_user_space_en, .cs1_bank_space_en, .cs_wide_port, .bank1_type, .bank0_type,
    .bank1_row_map, .bank0_row_map, .bank1_column_map, .bank0_column_map);
  memory_device_model mem (.clk, .data_out, .column_strobe_n, .data_in);
  // Expected data lanes: little order reverses the four bytes.
  function automatic logic [31:0] lanes(input logic [31:0] x, input logic b);
    return b ? x : {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  // Expected column strobes: little order reverses their numbering.
  function automatic logic [3:0] strobes(input logic [3:0] s, input logic b);
    return b ? s : {s[0], s[1], s[2], s[3]};
  endfunction
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  // One-cycle register read; data is taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    @(negedge clk) d = rdata;
  endtask
  // Reset held five cycles with the strap at the given level.
  task automatic reset_dut(input logic s);
    @(posedge clk) begin
      rst <= 1;
      boot_test_strap <= s;
    end
    repeat (5) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
  endtask
  // Prints the totals and the verdict, then stops.
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run time.
  initial begin
    #500000;
    n_errors++;
    conclude;
  end
  // Main sequence.
  initial begin
    reset_dut(1);
    rd(8'h00, w);
    `CHK("reset_value", 32'h1, w)
    `CHK("strobe_idle", 4'hf, column_strobe_n)
    // Field layout over random words, every bank type in both fields, bit 31 set at times.
    for (k = 0; k < 12; k++) begin
      w = (k == 0) ? 32'hffff_ffff : $random(seed);
      w[19:16] = {k[1:0], ~k[1:0]};
      wr(8'h00, w);
      @(negedge clk);
      `CHK("fields", {w[26:25], w[23:0]}, {remapper_two_en, remapper_one_en, cs_user_space_en, cs1_bank_space_en, bank1_type, bank0_type, bank1_row_map, bank0_row_map, bank1_column_map, bank0_column_map, cs_wide_port})
      rd(8'h00, ed);
      `CHK("readback", w & 32'h7fff_ffff, ed)
    end
    // An unmapped place reads zero and takes no write.
    wr(8'($random(seed)) | 8'h04, 32'h0);
    rd(8'h04, ed);
    `CHK("unmapped", 32'h0, ed)
    rd(8'h00, ed);
    `CHK("kept", w & 32'h7fff_ffff, ed)
    // Random lane traffic in both byte orders.
    for (k = 0; k < 24; k++) begin
      @(posedge clk) begin
        big_order <= k[0];
        core_wdata <= $random(seed);
        core_column_strobe_n <= 4'($random(seed));
        core_upper_mask <= 1'($random(seed));
        core_lower_mask <= 1'($random(seed));
      end
      @(posedge clk) ed = data_in;
      @(negedge clk);
      `CHK("data_out", lanes(core_wdata, big_order), data_out)
      `CHK("core_rdata", lanes(ed, big_order), core_rdata)
      `CHK("strobes", strobes(core_column_strobe_n, big_order), column_strobe_n)
      `CHK("masks", big_order ? {core_upper_mask, core_lower_mask} : {core_lower_mask, core_upper_mask}, {upper_byte_mask, lower_byte_mask})
    end
    // Clock pin floats during grant only with bit 30 set.
    wr(8'h00, 32'h4000_0000);
    @(posedge clk) external_bus_grant_n <= 0;
    @(posedge clk);
    @(negedge clk) `CHK("clock_float", 1'b1, memory_clock_oe_n)
    wr(8'h00, 32'h0);
    @(posedge clk);
    @(negedge clk) `CHK("clock_driven", 1'b0, memory_clock_oe_n)
    ed[0] = memory_clock_out;
    @(negedge clk) `CHK("clock_runs", ~ed[0], memory_clock_out)
    @(posedge clk) begin
      external_bus_grant_n <= 1;
      core_upper_mask <= 0;
      core_lower_mask <= 0;
    end
    // Masks held high after power-down exit unless bit 29 is set.
    for (k = 0; k < 2; k++) begin
      wr(8'h00, {2'b00, k[0], 29'h0});
      @(posedge clk) powerdown_exit <= 1;
      @(posedge clk) powerdown_exit <= 0;
      // The hold state was entered at the previous edge; the masks follow at this edge.
      @(posedge clk);
      repeat (3) @(negedge clk) `CHK("mask_hold", k[0] ? 2'b00 : 2'b11, {upper_byte_mask, lower_byte_mask})
      @(posedge clk) sdram_access <= 1;
      @(posedge clk) sdram_access <= 0;
      @(negedge clk) `CHK("mask_free", 2'b00, {upper_byte_mask, lower_byte_mask})
    end
    // Clock enable drops after the idle span and returns on access.
    wr(8'h00, 32'h1000_0000);
    for (k = 0; k < 2; k++) begin
      @(posedge clk) sdram_access <= 1;
      @(posedge clk) sdram_access <= 0;
      c = 0;
      repeat (12) @(negedge clk) if (sdram_clock_enable === 1'b1) c++;
      `CHK("idle_cycles", 8, c)
    end
    wr(8'h00, 32'h0);
    repeat (12) @(negedge clk);
    `CHK("no_powerdown", 1'b1, sdram_clock_enable)
    // Internal accesses shown only with bit 27 set.
    for (k = 0; k < 6; k++) begin
      en = (k < 4);
      wr(8'h00, {4'h0, en, 27'h0});
      @(posedge clk) internal_access <= '{1'b1, k[0], 13'($random(seed)), 32'($random(seed))};
      @(posedge clk) internal_access.valid <= 0;
      @(negedge clk);
      if (en) `CHK("show", {1'b0, ~internal_access.is_read, internal_access.addr, internal_access.data}, {card_register_select_n, show_read_n, show_addr, show_data})
      else `CHK("show_off", 1'b1, card_register_select_n)
      @(negedge clk) `CHK("show_end", 1'b1, card_register_select_n)
    end
    // Page hint honoured only with bit 24 set.
    for (k = 0; k < 4; k++) begin
      wr(8'h00, {7'h0, k[1], 24'h0});
      @(posedge clk) write_in_page_hint <= k[0];
      @(posedge clk);
      @(negedge clk) `CHK("keep_page", k[1] & k[0], keep_page)
    end
    // Strap tied low clears the chip-select 0 width bit.
    reset_dut(0);
    rd(8'h00, ed);
    `CHK("strap_low", 32'h0, ed)
    conclude;
  end
endmodule

// ### memory_config_cfg.svh
`ifndef MEMORY_CONFIG_CFG_SVH
`define MEMORY_CONFIG_CFG_SVH
// Register offset of the first memory configuration register.
`define MEMORY_CONFIG_ZERO_OFFSET 8'h00
// Field positions inside the configuration register.
`define POS_RESERVED 31
`define POS_CLOCK_FLOAT 30
`define POS_MASK_INIT_DIS 29
`define POS_IDLE_PD_EN 28
`define POS_DEBUG_SHOW 27
`define POS_REMAP_TWO 26
`define POS_REMAP_ONE 25
`define POS_PAGE_RETAIN 24
`define POS_CS3_USER 23
`define POS_CS2_USER 22
`define POS_CS1_USER 21
`define POS_CS1_BANK 20
`define POS_BANK1_TYPE 18
`define POS_BANK0_TYPE 16
`define POS_BANK1_ROW 14
`define POS_BANK0_ROW 12
`define POS_BANK1_COL 8
`define POS_BANK0_COL 4
`define POS_CS_WIDE 0
// Reset value of the register; the chip-select 0 width bit follows the strap.
`define MEMORY_CONFIG_ZERO_RESET 32'h0000_0000
// Clock period in nanoseconds and idle period before SDRAM power-down.
`define CLK_PERIOD_NS 100
`define IDLE_POWERDOWN_CYCLES 3'h7
`endif

// ### memory_config_pkg.sv
package memory_config_pkg;
  // Bank memory type encodings.
  typedef enum logic [1:0] {
    dram_16 = 2'b00,
    dram_32 = 2'b01,
    sdram_8 = 2'b10,
    sdram_16 = 2'b11
  } bank_type_e;
  // Byte-mask init state, Gray coded.
  typedef enum logic {
    mask_normal = 1'b0,
    mask_hold_high = 1'b1
  } mask_state_e;
  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  // Internal function register access shown for debug.
  typedef struct packed {
    logic valid;
    logic is_read;
    logic [12:0] addr;
    logic [31:0] data;
  } show_access_s;
endpackage

// ### memory_device_model.sv
`timescale 1ns/1ns
// Behavioural memory on the far side of the data lanes and column strobes.
module memory_device_model (
  input wire logic clk,
  input wire logic [31:0] data_out,
  input wire logic [3:0] column_strobe_n,
  output logic [31:0] data_in
);
  // Stored word, written one byte lane per active-low column strobe.
  logic [31:0] store = 32'h0;
  initial data_in = 32'h5a5a_c3c3;
  // Each selected lane takes the byte the controller drives.
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!column_strobe_n[i]) begin
        store[8*i +: 8] <= data_out[8*i +: 8];
      end
    end
  end
  // A selected device answers with the word; a deselected one leaves the bus
  // changing every cycle so that a stale value is never mistaken for data.
  always @(negedge clk) begin
    if (column_strobe_n != 4'hf) begin
      data_in <= store;
    end else begin
      data_in <= ~data_in;
    end
  end
endmodule
